// ### bspp_consts.svh
// timing constants and field layout for the bcd setpoint / process-variable port
`ifndef BSPP_CONSTS_SVH
`define BSPP_CONSTS_SVH

`define BSPP_CLK_NS          25
`define BSPP_DIGITS          4
`define BSPP_DIGIT_W         4
`define BSPP_DATA_W          16
`define BSPP_TOP_LSB         12
`define BSPP_NOT_READY       4'hF
`define BSPP_LOW_FILL        12'h000
`define BSPP_MAX_DIGIT       4'h9
`define BSPP_IDLE_LINES      16'hFFFF
`define BSPP_HOLD_US         80
`define BSPP_SP_HOLD_US      120
`define BSPP_RD_LOW_MS       330
`define BSPP_SETTLE_US       60
`define BSPP_CNT_W           24
`define BSPP_US_CYC(us)      (((us) * 1000 + `BSPP_CLK_NS - 1) / `BSPP_CLK_NS)
`define BSPP_MS_CYC(ms)      (((ms) * 1000000 + `BSPP_CLK_NS - 1) / `BSPP_CLK_NS)
`define BSPP_PV_LAT_DEF      100
`define BSPP_SP_RESET        16'h0000
`define BSPP_PV_RESET        16'h0000

`endif

// ### bspp_pkg.sv
// types shared by both ends of the bcd port
`default_nettype none
package bspp_pkg;
    typedef logic [15:0] bspp_bcd_t;
    typedef enum logic [2:0] {
        BSPP_IDLE, BSPP_SP_DRIVE, BSPP_SP_TAIL, BSPP_RD_WAIT, BSPP_RD_SETTLE, BSPP_RD_DONE
    } bspp_host_st_t;
    typedef enum logic [1:0] {
        BSPP_DV_LIVE, BSPP_DV_CONVERT, BSPP_DV_READY, BSPP_DV_LATCHED
    } bspp_dev_st_t;
endpackage : bspp_pkg
`default_nettype wire

// ### bspp_if.sv
// shared data lines and command lines between host and controller
`timescale 1ns/1ps
`default_nettype none
`include "bspp_consts.svh"
interface bspp_if;
    logic [15:0] host_dout;       // host data out
    logic        host_doe;        // host drives data lines
    logic [15:0] dev_dout;        // controller data out
    logic        dev_doe;         // controller drives data lines
    logic        dev_sign;        // negative temperature
    logic        remote_n;        // remote select, low = remote
    logic        sp_hold;         // setpoint hold, high = valid
    logic        rd_req_n;        // read request, low = convert
    logic [15:0] data;            // resolved data lines
    // pull-ups make undriven lines read high
    assign data = host_doe ? host_dout : (dev_doe ? dev_dout : `BSPP_IDLE_LINES);
    modport host (output host_dout, host_doe, remote_n, sp_hold, rd_req_n,
                  input data, dev_sign);
    modport dev  (output dev_dout, dev_doe, dev_sign,
                  input data, remote_n, sp_hold, rd_req_n);
endinterface : bspp_if
`default_nettype wire

// ### bspp_dev.sv
// controller end of the bcd setpoint / process-variable port
//----------------------------------------------------------------
//----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "bspp_consts.svh"
module bspp_dev #(
    parameter int unsigned PV_LAT = `BSPP_PV_LAT_DEF  // conversion time in cycles
) (
    input  wire logic             CLK_SYS,     // system clock, 40 MHz
    input  wire logic             ARST_N,      // async reset, active low
    bspp_if.dev                   LINK,        // port lines
    input  wire bspp_pkg::bspp_bcd_t PANEL_SP, // front-panel switch setpoint
    input  wire bspp_pkg::bspp_bcd_t PV_BCD,   // measured value, bcd
    input  wire logic             PV_NEG,      // measured value is negative
    output bspp_pkg::bspp_bcd_t   SETPOINT,    // setpoint in use
    output logic                  SP_REMOTE    // setpoint taken from remote port
);
    import bspp_pkg::*;

    //----------------------------------------------------------------
    // internal state
    //----------------------------------------------------------------
    bspp_bcd_t              stored_r;      // internal copy of remote setpoint
    logic                   hold_d_r;      // hold delayed, for edge detect
    logic                   hold_fell;     // first cycle with hold low
    bspp_dev_st_t           st_r;          // read sequence state
    bspp_dev_st_t           st_nxt;        // next read sequence state
    logic [`BSPP_CNT_W-1:0] conv_r;        // conversion cycles still to run
    bspp_bcd_t              pv_r;          // result frozen for the host
    logic                   neg_r;         // sign frozen with the result
    bspp_bcd_t              sp_r;          // setpoint in use
    logic                   rem_r;         // remote source selected
    logic                   drive_nxt;     // controller owns the lines next cycle

    //----------------------------------------------------------------
    // state decoding
    //----------------------------------------------------------------
    // the controller owns the lines in every state but the live one
    function automatic logic owns_lines(input bspp_dev_st_t st);
        return st != BSPP_DV_LIVE;
    endfunction : owns_lines

    // a fresh result is taken only while the sequence sits in ready
    function automatic logic takes_result(input bspp_dev_st_t st);
        return st == BSPP_DV_READY;
    endfunction : takes_result

    //----------------------------------------------------------------
    // setpoint capture
    //----------------------------------------------------------------
    // the fall is seen one edge late; the host keeps data 120 us, so that is ample
    assign hold_fell = hold_d_r && !LINK.sp_hold;

    // history rests high like the idle line, so reset makes no false fall
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            hold_d_r <= 1'b1;
        else
            hold_d_r <= LINK.sp_hold;
    end

    // copy follows the lines while valid and once more on the fall; a host that
    // changes data in the first cycle with hold low spoils the copy, and nothing here can tell
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            stored_r <= `BSPP_SP_RESET;
        else if (LINK.sp_hold || hold_fell)
            stored_r <= LINK.data;
    end

    //----------------------------------------------------------------
    // setpoint selection
    //----------------------------------------------------------------
    // source flag for the outside world, one cycle behind the pin
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            rem_r <= 1'b0;
        else
            rem_r <= !LINK.remote_n;
    end

    // live port while hold is high, stored copy while the host reads back;
    // the panel wins whenever remote select is high, even in mid-read
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            sp_r <= `BSPP_SP_RESET;
        else if (LINK.remote_n)
            sp_r <= PANEL_SP;
        else if (LINK.sp_hold)
            sp_r <= LINK.data;
        else
            sp_r <= stored_r;
    end
    assign SETPOINT  = sp_r;
    assign SP_REMOTE = rem_r;

    //----------------------------------------------------------------
    // process-variable read sequence
    //----------------------------------------------------------------
    // hold high sends every state back to live, whatever the host did before
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            BSPP_DV_LIVE: begin
                if (!LINK.sp_hold && !LINK.rd_req_n)
                    st_nxt = BSPP_DV_CONVERT;
            end
            BSPP_DV_CONVERT: begin
                if (LINK.sp_hold)
                    st_nxt = BSPP_DV_LIVE;
                else if (conv_r == '0)
                    st_nxt = BSPP_DV_READY;
            end
            BSPP_DV_READY: begin
                if (LINK.sp_hold)
                    st_nxt = BSPP_DV_LIVE;
                else if (LINK.rd_req_n)
                    st_nxt = BSPP_DV_LATCHED;
            end
            BSPP_DV_LATCHED: begin
                if (LINK.sp_hold)
                    st_nxt = BSPP_DV_LIVE;
            end
        endcase
    end
    assign drive_nxt = owns_lines(st_nxt);

    // sequence register
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            st_r <= BSPP_DV_LIVE;
        else
            st_r <= st_nxt;
    end

    //----------------------------------------------------------------
    // conversion and result
    //----------------------------------------------------------------
    // reloaded while live, so every read waits the full conversion time;
    // a request that rises before the count ends still waits for it
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            conv_r <= '0;
        else if (!owns_lines(st_r))
            conv_r <= PV_LAT[`BSPP_CNT_W-1:0];
        else if (conv_r != '0)
            conv_r <= conv_r - 1'b1;
    end

    // result tracks the live value in ready until the host freezes it by raising rd_req_n again
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pv_r  <= `BSPP_PV_RESET;
            neg_r <= 1'b0;
        end else if (takes_result(st_nxt)) begin
            pv_r  <= PV_BCD;
            neg_r <= PV_NEG;
        end
    end

    //----------------------------------------------------------------
    // line drivers
    //----------------------------------------------------------------
    // drive from the read request until hold rises, also while the host drives in its done step; the release
    // lags hold by one cycle, which the host side has to tolerate
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            LINK.dev_doe <= 1'b0;
        else
            LINK.dev_doe <= drive_nxt;
    end

    // not-ready marker, then the live result, then the frozen copy
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            LINK.dev_dout <= `BSPP_PV_RESET;
        else if (st_nxt == BSPP_DV_CONVERT)
            LINK.dev_dout <= {`BSPP_NOT_READY, `BSPP_LOW_FILL};
        else if (takes_result(st_nxt))
            LINK.dev_dout <= PV_BCD;
        else if (st_nxt == BSPP_DV_LATCHED)
            LINK.dev_dout <= pv_r;
    end

    // sign only means something beside a result, so it rests low otherwise
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            LINK.dev_sign <= 1'b0;
        else if (!drive_nxt || st_nxt == BSPP_DV_CONVERT)
            LINK.dev_sign <= 1'b0;
        else if (takes_result(st_nxt))
            LINK.dev_sign <= PV_NEG;
        else
            LINK.dev_sign <= neg_r;
    end
endmodule : bspp_dev
`default_nettype wire

// ### bspp_host.sv
// host end: writes setpoint, reads process variable by either method
`timescale 1ns/1ps
`default_nettype none
`include "bspp_consts.svh"
module bspp_host #(
    parameter int unsigned RD_LOW_CYC = `BSPP_MS_CYC(`BSPP_RD_LOW_MS) // timed-read low time
) (
    input  wire logic             CLK_SYS,    // system clock, 40 MHz
    input  wire logic             ARST_N,     // async reset, active low
    bspp_if.host                  LINK,       // port lines
    input  wire logic             REMOTE_EN,  // use remote setpoint
    input  wire bspp_pkg::bspp_bcd_t SP_IN,   // setpoint to write
    input  wire logic             RD_START,   // pulse: start a read
    input  wire logic             RD_TIMED,   // 1 = timed method, 0 = polled
    output bspp_pkg::bspp_bcd_t   PV_OUT,     // value read
    output logic                  PV_NEG,     // value negative
    output logic                  PV_VALID,   // pulse: read complete
    output logic                  BUSY        // read in progress
);
    import bspp_pkg::*;

    bspp_host_st_t st_r;
    logic [`BSPP_CNT_W-1:0] cnt_r;
    logic          timed_r;
    bspp_bcd_t     pv_r;
    logic          neg_r;
    logic          vld_r;

    // top digit valid once it is a decimal value
    function automatic logic top_ok(input logic [15:0] d);
        return d[`BSPP_DATA_W-1:`BSPP_TOP_LSB] <= `BSPP_MAX_DIGIT;
    endfunction : top_ok

    //----------------------------------------------------------------
    // read sequencer
    //----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r    <= BSPP_IDLE;
            cnt_r   <= '0;
            timed_r <= 1'b0;
            pv_r    <= `BSPP_PV_RESET;
            neg_r   <= 1'b0;
            vld_r   <= 1'b0;
        end else begin
            vld_r <= 1'b0;
            if (cnt_r != '0)
                cnt_r <= cnt_r - 1'b1;
            unique case (st_r)
                BSPP_IDLE: if (RD_START) begin
                    timed_r <= RD_TIMED;
                    cnt_r   <= `BSPP_CNT_W'(`BSPP_US_CYC(`BSPP_SP_HOLD_US));
                    st_r    <= BSPP_SP_TAIL;
                end
                BSPP_SP_TAIL: if (cnt_r == '0) begin
                    cnt_r <= RD_LOW_CYC[`BSPP_CNT_W-1:0];
                    st_r  <= BSPP_RD_WAIT;
                end
                BSPP_RD_WAIT: if (timed_r ? (cnt_r == '0) : top_ok(LINK.data)) begin
                    cnt_r <= `BSPP_CNT_W'(`BSPP_US_CYC(`BSPP_SETTLE_US));
                    st_r  <= BSPP_RD_SETTLE;
                end
                BSPP_RD_SETTLE: if (cnt_r == '0) begin
                    pv_r  <= LINK.data;
                    neg_r <= LINK.dev_sign;
                    st_r  <= BSPP_RD_DONE;
                end
                BSPP_RD_DONE: begin
                    vld_r <= 1'b1;
                    st_r  <= BSPP_IDLE;
                end
                default: st_r <= BSPP_IDLE;
            endcase
        end
    end

    // line drive; setpoint back on lines a cycle before hold rises
    always_comb begin
        LINK.host_dout = SP_IN;
        LINK.host_doe  = (st_r == BSPP_IDLE) || (st_r == BSPP_SP_TAIL) ||
                         (st_r == BSPP_RD_DONE);
        LINK.sp_hold   = (st_r == BSPP_IDLE);
        LINK.rd_req_n  = !(st_r == BSPP_RD_WAIT);
        LINK.remote_n  = !REMOTE_EN;
    end

    assign PV_OUT   = pv_r;
    assign PV_NEG   = neg_r;
    assign PV_VALID = vld_r;
    assign BUSY     = (st_r != BSPP_IDLE);
endmodule : bspp_host
`default_nettype wire

// ### bspp_props.sv
// concurrent checks on the bcd port lines between host and controller
`timescale 1ns/1ps
`default_nettype none
`include "bspp_consts.svh"
module bspp_props (
    input wire logic        CLK_SYS,   // system clock
    input wire logic        ARST_N,    // async reset, active low
    input wire logic [15:0] host_dout, // host data out
    input wire logic        host_doe,  // host drives lines
    input wire logic [15:0] dev_dout,  // controller data out
    input wire logic        dev_doe,   // controller drives lines
    input wire logic        dev_sign,  // negative temperature
    input wire logic        sp_hold,   // setpoint hold
    input wire logic        rd_req_n,  // read request, active low
    input wire logic [15:0] data       // resolved lines
);
    localparam int SP_TAIL = `BSPP_US_CYC(`BSPP_SP_HOLD_US);
    logic [15:0] low_cnt_r;            // cycles with hold low
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // -----
    // hold-low counter: a counter, since the tail is far past any repetition
    // -----
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N)
            low_cnt_r <= 16'h0000;
        else if (sp_hold)
            low_cnt_r <= 16'h0000;
        else
            low_cnt_r <= low_cnt_r + 16'h0001;
    end
    // controller side
    a_top_digit_ff: assert property ($rose(dev_doe) |-> dev_dout[15:12] == 4'hF)
        else $error("top digit not all ones when drive starts");
    a_drive_cause: assert property ($rose(dev_doe) |-> $past(!sp_hold && !rd_req_n))
        else $error("controller drove lines without hold low and request low");
    a_release_hold: assert property ($rose(sp_hold) |=> !dev_doe)
        else $error("controller still drives after hold rose");
    a_frozen_data: assert property (dev_doe && rd_req_n && $past(rd_req_n) && $past(dev_doe)
        |-> $stable({dev_sign, dev_dout}))
        else $error("latched value changed during host read");
    a_sign_idle: assert property (!dev_doe |-> !dev_sign)
        else $error("sign line high while lines released");
    // host side
    a_host_tail: assert property ($fell(host_doe) |-> low_cnt_r >= 16'(SP_TAIL))
        else $error("host released lines before the hold tail ended");
    a_req_release: assert property ($fell(rd_req_n) |-> !host_doe)
        else $error("read request while host still drives");
    a_req_in_hold: assert property (!rd_req_n |-> !sp_hold)
        else $error("read request low with hold high");
    a_restore_order: assert property ($rose(sp_hold)
        |-> host_doe && $past(host_doe) && data == host_dout)
        else $error("hold rose before setpoint was restored");
endmodule : bspp_props
`default_nettype wire

// ### tb_bcd_setpoint_pv_port.sv
// self-checking bench: both port ends joined, user sides driven
`timescale 1ns/1ps
`default_nettype none
module tb_bcd_setpoint_pv_port;
    import bspp_pkg::*;
    logic      clk_sys = 1'b0, arst_n = 1'b0, remote_en = 1'b0;
    logic      rd_start = 1'b0, rd_timed = 1'b0, pv_neg_in = 1'b0;
    bspp_bcd_t panel_sp = 16'h1234, sp_in = 16'h0567, pv_bcd = 16'h0000;
    bspp_bcd_t setpoint, pv_out;
    logic      sp_remote, pv_neg_out, pv_valid, busy;
    int        fail_count = 0;
    int        n_tests = 0;
    bspp_if lnk();
    always #12.5 clk_sys = ~clk_sys;
    // short conversion so the timed read (100 cycles low) sees a result
    bspp_dev #(.PV_LAT(40)) bspp_dev_inst (.CLK_SYS(clk_sys), .ARST_N(arst_n), .LINK(lnk),
        .PANEL_SP(panel_sp), .PV_BCD(pv_bcd), .PV_NEG(pv_neg_in), .SETPOINT(setpoint),
        .SP_REMOTE(sp_remote));
    bspp_host #(.RD_LOW_CYC(100)) bspp_host_inst (.CLK_SYS(clk_sys), .ARST_N(arst_n),
        .LINK(lnk), .REMOTE_EN(remote_en), .SP_IN(sp_in), .RD_START(rd_start),
        .RD_TIMED(rd_timed), .PV_OUT(pv_out), .PV_NEG(pv_neg_out), .PV_VALID(pv_valid),
        .BUSY(busy));
    bspp_props bspp_props_inst (.CLK_SYS(clk_sys), .ARST_N(arst_n),
        .host_dout(lnk.host_dout), .host_doe(lnk.host_doe), .dev_dout(lnk.dev_dout),
        .dev_doe(lnk.dev_doe), .dev_sign(lnk.dev_sign), .sp_hold(lnk.sp_hold),
        .rd_req_n(lnk.rd_req_n), .data(lnk.data));
    // -----
    // helpers
    // -----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // one read; a second start mid-read must be ignored
    task automatic read_pv(input logic timed, input bspp_bcd_t pv, input logic neg);
        int n;
        n = 0;
        pv_bcd = pv;
        pv_neg_in = neg;
        rd_timed = timed;
        rd_start = 1'b1;
        @(negedge clk_sys);
        rd_start = 1'b0;
        while (!lnk.dev_doe && n < 8000) begin
            @(negedge clk_sys);
            n++;
        end
        chk({11'h000, lnk.dev_doe, lnk.data[15:12]}, 16'h001F);
        repeat (20) @(negedge clk_sys);
        chk(setpoint, sp_in);
        rd_start = 1'b1;
        @(negedge clk_sys);
        rd_start = 1'b0;
        while (!pv_valid && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        chk({15'h0000, pv_valid}, 16'h0001);
        chk(pv_out, pv);
        chk({15'h0000, pv_neg_out}, {15'h0000, neg});
        repeat (4) @(negedge clk_sys);
        chk({14'h0000, busy, lnk.dev_doe}, 16'h0000);
        chk(lnk.data, sp_in);
        chk(setpoint, sp_in);
    endtask : read_pv
    // two full reads plus margin, well under this span
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(setpoint, panel_sp);
        chk({15'h0000, sp_remote}, 16'h0000);
        remote_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(setpoint, sp_in);
        chk({15'h0000, sp_remote}, 16'h0001);
        sp_in = 16'h0789;
        repeat (3) @(negedge clk_sys);
        chk(setpoint, 16'h0789);
        read_pv(1'b0, 16'h0425, 1'b1);
        read_pv(1'b1, 16'h4999, 1'b0);
        remote_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(setpoint, panel_sp);
        end_sim();
    end
endmodule : tb_bcd_setpoint_pv_port
`default_nettype wire
